// [rtl/cpu_mode_exception_control.sv]
// Status word, banked stack pointers and prioritised exception entry.
// Function
// - Status bit 7 set masks normal interrupts.
// - Status bit 6 set masks fast interrupts.
// - Status bit 5 selects compact 16-bit (1) or 32-bit (0) instruction state.
// - Status bits 4:0 encode the seven execution modes.
// - Status bits 27:8 are reserved, read zero, hold no function.
// - Status bits 31:28 hold negative, zero, carry and overflow flags.
// - Priority: reset, data abort, fast, normal, prefetch abort, undefined or trap.
// - Trap and undefined share the lowest level and never coincide.
// - Vector base is 0000_0000h, or FFFF_0000h when high vectors are selected, except for the reset entry.
// - Reset fetches offset 0h in supervisor mode with both masks set.
// - Undefined goes to 04h, undefined mode, normal mask set.
// - Trap goes to 08h, supervisor mode, normal mask set.
// - Prefetch abort goes to 0Ch, abort mode, normal mask set.
// - Data abort goes to 10h, abort mode, normal mask set.
// - Normal interrupt goes to 18h, normal-interrupt mode, normal mask set.
// - Mode writes reach privileged modes only from privileged modes; user leaves only by exception entry.
// - Each mode change switches to that mode's banked stack pointer; MODE_OS shares the user bank.
// - Branch-exchange updates the instruction state bit.
module cpu_mode_exception_control
  import psw_pkg::*;
(
  input  wire logic        clk_sys,           // System clock, 50 MHz.
  input  wire logic        resetn,            // Asynchronous reset, active low.
  input  wire logic [3:0]  avs_address,       // Register byte address.
  input  wire logic        avs_read,          // Read request.
  input  wire logic        avs_write,         // Write request.
  input  wire logic [31:0] avs_writedata,     // Write data.
  input  wire logic [3:0]  avs_byteenable,    // Byte lanes of a write.
  output logic      [31:0] avs_readdata,      // Read data.
  output logic             avs_waitrequest,   // Stall until the answer stands.
  input  wire logic        fiq_req,           // Fast interrupt request pin.
  input  wire logic        irq_req,           // Normal interrupt request pin.
  input  wire logic        high_vector_select,// High vector strap pin.
  input  wire logic        data_abort,        // Data access could not complete.
  input  wire logic        prefetch_abort,    // Fetch could not complete.
  input  wire logic        illegal_opcode,    // Undefined instruction seen.
  input  wire logic        software_trap,     // Trap instruction executed.
  input  wire logic        branch_exchange,   // Branch-exchange executed.
  input  wire logic        bx_target_state,   // New state bit for branch-exchange.
  input  wire logic        flags_we,          // Load condition flags from the ALU.
  input  wire logic [3:0]  alu_flags,         // Negative, zero, carry, overflow.
  input  wire logic        mode_we,           // Pipeline request to change mode.
  input  wire logic [4:0]  mode_new,          // Requested mode code.
  input  wire logic [31:0] return_addr,       // Return address for entry.
  output logic      [31:0] psw_out,           // Current status word.
  output logic      [31:0] stack_pointer,     // Active banked stack pointer.
  output logic             vector_valid,      // One-cycle fetch redirect pulse.
  output logic      [31:0] vector_addr,       // Fetch address on redirect.
  output logic      [31:0] saved_psw,         // Saved status of the target mode.
  output logic      [31:0] saved_return       // Saved return of the target mode.
);

  logic        fiq_s1_q, fiq_q, irq_s1_q, irq_q, hv_s1_q, hv_q;
  logic [31:0] psw_q, psw_d;
  logic        hivec_ctrl_q;
  logic        entry_pend_q;
  logic [31:0] sp_bank_q [BANKS];
  logic [31:0] spsr_q [BANKS];
  logic [31:0] ret_q [BANKS];
  logic        take_d;
  logic [4:0]  mode_d;
  logic [7:0]  voff_d;
  logic        set_fiq_mask_d;
  logic        rd_pend_q;

  // Pins from other sources pass two flops before any logic looks at them.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fiq_s1_q <= 1'b0;
      fiq_q    <= 1'b0;
      irq_s1_q <= 1'b0;
      irq_q    <= 1'b0;
      hv_s1_q  <= 1'b0;
      hv_q     <= 1'b0;
    end else begin
      fiq_s1_q <= fiq_req;
      fiq_q    <= fiq_s1_q;
      irq_s1_q <= irq_req;
      irq_q    <= irq_s1_q;
      hv_s1_q  <= high_vector_select;
      hv_q     <= hv_s1_q;
    end
  end

  function automatic logic [2:0] bank_of(input logic [4:0] m);
    logic [2:0] b;
    b = BANK_USER;
    unique case (m)
      MODE_FIQ:  b = BANK_FIQ;
      MODE_IRQ:  b = BANK_IRQ;
      MODE_SUPV: b = BANK_SUPV;
      MODE_ABRT: b = BANK_ABRT;
      MODE_ILLG: b = BANK_ILLG;
      default:   b = BANK_USER;
    endcase
    return b;
  endfunction : bank_of

  // Exception selection, highest first; reset is handled by the entry pending flag.
  // Interrupt levels use the synchronised copies, so they act two cycles after the pin moves.
  always_comb begin
    take_d         = 1'b1;
    mode_d         = MODE_SUPV;
    voff_d         = VOFF_RESET;
    set_fiq_mask_d = 1'b1;
    if (entry_pend_q) begin
      mode_d = MODE_SUPV;
    end else if (data_abort) begin
      mode_d = MODE_ABRT;
      voff_d = VOFF_DATA;
      set_fiq_mask_d = 1'b0;
    end else if (fiq_q && !psw_q[BIT_FIQ_MASK]) begin
      mode_d = MODE_FIQ;
      voff_d = VOFF_FIQ;
    end else if (irq_q && !psw_q[BIT_IRQ_MASK]) begin
      mode_d = MODE_IRQ;
      voff_d = VOFF_IRQ;
      set_fiq_mask_d = 1'b0;
    end else if (prefetch_abort) begin
      mode_d = MODE_ABRT;
      voff_d = VOFF_PREFETCH;
      set_fiq_mask_d = 1'b0;
    end else if (illegal_opcode) begin
      mode_d = MODE_ILLG;
      voff_d = VOFF_ILLEGAL;
      set_fiq_mask_d = 1'b0;
    end else if (software_trap) begin
      mode_d = MODE_SUPV;
      voff_d = VOFF_TRAP;
      set_fiq_mask_d = 1'b0;
    end else begin
      take_d = 1'b0;
    end
  end

  // A mode write from user mode into a privileged mode is ignored.
  function automatic logic mode_ok(input logic [4:0] cur, input logic [4:0] nxt);
    logic ok;
    ok = 1'b0;
    unique case (nxt)
      MODE_USER, MODE_FIQ, MODE_IRQ, MODE_SUPV,
      MODE_ABRT, MODE_ILLG, MODE_OS: ok = (cur != MODE_USER) || (nxt == MODE_USER);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : mode_ok

  // Writes land on the edge that samples waitrequest low, the last edge the master holds for.
  logic sw_psw_wr;
  logic sp_wr;
  assign sw_psw_wr = avs_write && !avs_waitrequest && (avs_address == ADDR_PSW);
  assign sp_wr     = avs_write && !avs_waitrequest && (avs_address == ADDR_SP);

  // Exception entry wins over every other writer of the status word in the same cycle.
  always_comb begin
    psw_d = psw_q;
    if (take_d) begin
      psw_d[MODE_HI:MODE_LO] = mode_d;
      psw_d[BIT_IRQ_MASK]    = 1'b1;
      psw_d[BIT_STATE]       = 1'b0;
      if (set_fiq_mask_d) begin
        psw_d[BIT_FIQ_MASK] = 1'b1;
      end
    end else begin
      if (flags_we) begin
        psw_d[FLAG_HI:FLAG_LO] = alu_flags;
      end
      if (branch_exchange) begin
        psw_d[BIT_STATE] = bx_target_state;
      end
      if (mode_we && mode_ok(psw_q[MODE_HI:MODE_LO], mode_new)) begin
        psw_d[MODE_HI:MODE_LO] = mode_new;
      end
      if (sw_psw_wr && (psw_q[MODE_HI:MODE_LO] != MODE_USER)
          && mode_ok(psw_q[MODE_HI:MODE_LO], avs_writedata[MODE_HI:MODE_LO])) begin
        for (int i = 0; i < 4; i++) begin
          if (avs_byteenable[i]) begin
            psw_d[i*8 +: 8] = avs_writedata[i*8 +: 8];
          end
        end
      end
    end
    psw_d = psw_d & PSW_WMASK;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      psw_q        <= PSW_RESET;
      entry_pend_q <= 1'b1;
    end else begin
      psw_q        <= psw_d;
      entry_pend_q <= 1'b0;
    end
  end

  // Saved status and return address land in the target mode's bank.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < BANKS; i++) begin
        spsr_q[i] <= '0;
        ret_q[i]  <= '0;
      end
    end else if (take_d) begin
      spsr_q[bank_of(mode_d)] <= psw_q;
      ret_q[bank_of(mode_d)]  <= return_addr;
    end
  end

  // Fetch redirect; offset 14h is never produced by the selector.
  // Between entries the saved copies follow the bank of the mode in force, as the pointer does.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      vector_valid <= 1'b0;
      vector_addr  <= VEC_BASE_LOW;
      saved_psw    <= '0;
      saved_return <= '0;
    end else begin
      vector_valid <= take_d;
      if (take_d) begin
        vector_addr  <= ((hv_q || hivec_ctrl_q) ? VEC_BASE_HIGH : VEC_BASE_LOW)
                        | {24'h000000, voff_d};
        saved_psw    <= psw_q;
        saved_return <= return_addr;
      end else begin
        saved_psw    <= spsr_q[bank_of(psw_d[MODE_HI:MODE_LO])];
        saved_return <= ret_q[bank_of(psw_d[MODE_HI:MODE_LO])];
      end
    end
  end

  // Stack pointers are written by software in the current mode's bank.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < BANKS; i++) begin
        sp_bank_q[i] <= '0;
      end
    end else if (sp_wr) begin
      sp_bank_q[bank_of(psw_q[MODE_HI:MODE_LO])] <= avs_writedata;
    end
  end

  // The active pointer is loaded with the status word, so both change on the same edge.
  // It lags one cycle behind a software write to the bank that is already active.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stack_pointer <= '0;
      psw_out       <= PSW_RESET;
    end else begin
      stack_pointer <= sp_bank_q[bank_of(psw_d[MODE_HI:MODE_LO])];
      psw_out       <= psw_d;
    end
  end

  // Control register; the high vector bit resets to zero and is written by software.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hivec_ctrl_q <= 1'b0;
    end else if (avs_write && !avs_waitrequest && (avs_address == ADDR_CTRL)
                 && avs_byteenable[0]) begin
      hivec_ctrl_q <= avs_writedata[CTRL_HIVEC];
    end
  end

  // Every access waits one cycle, then completes; unmapped reads return zero.
  // Read data is captured on the accepting edge and stands through the completion edge.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
      rd_pend_q       <= 1'b0;
    end else begin
      rd_pend_q <= 1'b0;
      if ((avs_read || avs_write) && avs_waitrequest && !rd_pend_q) begin
        avs_waitrequest <= 1'b0;
        rd_pend_q       <= 1'b1;
        unique case (avs_address)
          ADDR_PSW:    avs_readdata <= psw_q;
          ADDR_CTRL:   avs_readdata <= {31'h00000000, hivec_ctrl_q};
          ADDR_SP:     avs_readdata <= sp_bank_q[bank_of(psw_q[MODE_HI:MODE_LO])];
          ADDR_VECTOR: avs_readdata <= vector_addr;
          default:     avs_readdata <= '0;
        endcase
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

  // Entry checks on the vector, the new status word and, for carried masks, the one that it replaced.
  cause_order_a : assert property (@(posedge clk_sys) disable iff (!resetn)
    (data_abort && !entry_pend_q) |=> (vector_addr[7:0] == VOFF_DATA))
    else $error("data abort did not win");
  irq_masked_a : assert property (@(posedge clk_sys) disable iff (!resetn)
    vector_valid |-> psw_out[BIT_IRQ_MASK])
    else $error("normal mask not set on entry");
  fiq_entry_a : assert property (@(posedge clk_sys) disable iff (!resetn)
    (vector_valid && vector_addr[7:0] == VOFF_FIQ) |-> psw_out[BIT_FIQ_MASK]
      && psw_out[MODE_HI:MODE_LO] == MODE_FIQ)
    else $error("fast entry wrong");
  reset_entry_a : assert property (@(posedge clk_sys) disable iff (!resetn)
    (vector_valid && vector_addr[7:0] == VOFF_RESET)
      |-> psw_out[MODE_HI:MODE_LO] == MODE_SUPV
      && psw_out[BIT_IRQ_MASK] && psw_out[BIT_FIQ_MASK])
    else $error("reset entry wrong");
  illegal_entry_a : assert property (@(posedge clk_sys) disable iff (!resetn)
    (vector_valid && vector_addr[7:0] == VOFF_ILLEGAL)
      |-> psw_out[MODE_HI:MODE_LO] == MODE_ILLG
      && psw_out[BIT_FIQ_MASK] == $past(psw_q[BIT_FIQ_MASK]))
    else $error("undefined entry wrong");
  trap_entry_a : assert property (@(posedge clk_sys) disable iff (!resetn)
    (vector_valid && vector_addr[7:0] == VOFF_TRAP)
      |-> psw_out[MODE_HI:MODE_LO] == MODE_SUPV
      && psw_out[BIT_FIQ_MASK] == $past(psw_q[BIT_FIQ_MASK]))
    else $error("trap entry wrong");
  abort_entry_a : assert property (@(posedge clk_sys) disable iff (!resetn)
    (vector_valid && (vector_addr[7:0] == VOFF_PREFETCH || vector_addr[7:0] == VOFF_DATA))
      |-> psw_out[MODE_HI:MODE_LO] == MODE_ABRT
      && psw_out[BIT_FIQ_MASK] == $past(psw_q[BIT_FIQ_MASK]))
    else $error("abort entry wrong");
  irq_entry_a : assert property (@(posedge clk_sys) disable iff (!resetn)
    (vector_valid && vector_addr[7:0] == VOFF_IRQ)
      |-> psw_out[MODE_HI:MODE_LO] == MODE_IRQ && !$past(psw_q[BIT_IRQ_MASK])
      && psw_out[BIT_FIQ_MASK] == $past(psw_q[BIT_FIQ_MASK]))
    else $error("normal interrupt entry wrong");
  fiq_unmasked_a : assert property (@(posedge clk_sys) disable iff (!resetn)
    (vector_valid && vector_addr[7:0] == VOFF_FIQ) |-> !$past(psw_q[BIT_FIQ_MASK]))
    else $error("masked fast interrupt taken");
  state_clear_a : assert property (@(posedge clk_sys) disable iff (!resetn)
    vector_valid |-> !psw_out[BIT_STATE])
    else $error("state bit not cleared on entry");
  vector_base_a : assert property (@(posedge clk_sys) disable iff (!resetn)
    vector_valid |-> vector_addr[31:8]
      == ($past(hv_q || hivec_ctrl_q) ? VEC_BASE_HIGH[31:8] : VEC_BASE_LOW[31:8]))
    else $error("vector base wrong");
  no_reserved_a : assert property (@(posedge clk_sys) disable iff (!resetn)
    vector_valid |-> vector_addr[7:0] != VOFF_RESERVED)
    else $error("reserved vector used");

  // Status word fields, mode changes outside entry and the active pointer.
  reserved_zero_a : assert property (@(posedge clk_sys) disable iff (!resetn)
    psw_out[27:8] == 20'h00000)
    else $error("reserved bits set");
  user_priv_a : assert property (@(posedge clk_sys) disable iff (!resetn)
    ($past(psw_out[MODE_HI:MODE_LO]) == MODE_USER && !vector_valid)
      |-> psw_out[MODE_HI:MODE_LO] == MODE_USER)
    else $error("user escaped without exception");
  flag_load_a : assert property (@(posedge clk_sys) disable iff (!resetn)
    (flags_we && !take_d) |=> psw_out[FLAG_HI:FLAG_LO] == $past(alu_flags))
    else $error("flags not loaded");
  state_bit_a : assert property (@(posedge clk_sys) disable iff (!resetn)
    (branch_exchange && !take_d) |=> psw_out[BIT_STATE] == $past(bx_target_state))
    else $error("state bit not updated");
  sp_select_a : assert property (@(posedge clk_sys) disable iff (!resetn)
    !$past(sp_wr) |-> stack_pointer == sp_bank_q[bank_of(psw_out[MODE_HI:MODE_LO])])
    else $error("stack pointer bank wrong");

  // Bus handshake: one wait state, then a single-cycle answer.
  bus_answer_a : assert property (@(posedge clk_sys) disable iff (!resetn)
    !avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
  wait_one_a : assert property (@(posedge clk_sys) disable iff (!resetn)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("answer held too long");

endmodule : cpu_mode_exception_control

// [pkg/psw_pkg.sv]
// Constants for the status word, mode codes, vector offsets and register map.
package psw_pkg;
  localparam int          PSW_W         = 32;
  localparam int          BIT_IRQ_MASK  = 7;
  localparam int          BIT_FIQ_MASK  = 6;
  localparam int          BIT_STATE     = 5;
  localparam int          MODE_LO       = 0;
  localparam int          MODE_HI       = 4;
  localparam int          FLAG_LO       = 28;
  localparam int          FLAG_HI       = 31;
  localparam logic [31:0] PSW_WMASK     = 32'hF00000FF;
  localparam logic [31:0] PSW_RESET     = 32'h000000D3;

  typedef enum logic [4:0] {
    MODE_USER = 5'h10,
    MODE_FIQ  = 5'h11,
    MODE_IRQ  = 5'h12,
    MODE_SUPV = 5'h13,
    MODE_ABRT = 5'h17,
    MODE_ILLG = 5'h1B,
    MODE_OS   = 5'h1F
  } cpu_mode_t;

  localparam logic [31:0] VEC_BASE_LOW  = 32'h00000000;
  localparam logic [31:0] VEC_BASE_HIGH = 32'hFFFF0000;
  localparam logic [7:0]  VOFF_RESET    = 8'h00;
  localparam logic [7:0]  VOFF_ILLEGAL  = 8'h04;
  localparam logic [7:0]  VOFF_TRAP     = 8'h08;
  localparam logic [7:0]  VOFF_PREFETCH = 8'h0C;
  localparam logic [7:0]  VOFF_DATA     = 8'h10;
  localparam logic [7:0]  VOFF_RESERVED = 8'h14;
  localparam logic [7:0]  VOFF_IRQ      = 8'h18;
  localparam logic [7:0]  VOFF_FIQ      = 8'h1C;

  // Avalon byte addresses.
  localparam logic [3:0]  ADDR_PSW      = 4'h0;
  localparam logic [3:0]  ADDR_CTRL     = 4'h4;
  localparam logic [3:0]  ADDR_SP       = 4'h8;
  localparam logic [3:0]  ADDR_VECTOR   = 4'hC;
  localparam int          CTRL_HIVEC    = 0;
  localparam int          BANKS         = 6;
  localparam logic [2:0]  BANK_USER     = 3'd0;
  localparam logic [2:0]  BANK_FIQ      = 3'd1;
  localparam logic [2:0]  BANK_IRQ      = 3'd2;
  localparam logic [2:0]  BANK_SUPV     = 3'd3;
  localparam logic [2:0]  BANK_ABRT     = 3'd4;
  localparam logic [2:0]  BANK_ILLG     = 3'd5;
endpackage : psw_pkg

// [test/exception_source_model.sv]
// Pipeline, interrupt controller and abort sources that face the exception unit.
module exception_source_model (
  input  wire logic        clk_sys,            // System clock.
  output logic             fiq_req,            // Fast interrupt level.
  output logic             irq_req,            // Normal interrupt level.
  output logic             high_vector_select, // High vector strap.
  output logic             data_abort,         // Data abort pulse.
  output logic             prefetch_abort,     // Prefetch abort pulse.
  output logic             illegal_opcode,     // Undefined instruction pulse.
  output logic             software_trap,      // Trap instruction pulse.
  output logic             branch_exchange,    // Branch-exchange pulse.
  output logic             bx_target_state,    // New state for branch-exchange.
  output logic             flags_we,           // Flag load pulse.
  output logic      [3:0]  alu_flags,          // Negative, zero, carry, overflow.
  output logic             mode_we,            // Mode change request pulse.
  output logic      [4:0]  mode_new,           // Requested mode.
  output logic      [31:0] return_addr         // Return address offered on entry.
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {fiq_req, irq_req, data_abort, prefetch_abort, illegal_opcode, software_trap} = 6'h00;
    {branch_exchange, bx_target_state, flags_we, mode_we} = 4'h0;
    high_vector_select = 1'b0;
    alu_flags = 4'h0;
    mode_new = 5'h10;
    return_addr = 32'h00001234;
  end
  // Order is data, prefetch, illegal, trap; callers never set the last two together.
  task automatic pulse(input logic [3:0] cause);
    @(posedge clk_sys);
    {data_abort, prefetch_abort, illegal_opcode, software_trap} <= cause;
    @(posedge clk_sys);
    {data_abort, prefetch_abort, illegal_opcode, software_trap} <= 4'h0;
  endtask : pulse
  task automatic set_int(input logic f, input logic i);
    @(posedge clk_sys);
    fiq_req <= f;
    irq_req <= i;
  endtask : set_int
  task automatic pipe(input logic fw, input logic [3:0] fl, input logic bx, input logic st,
                      input logic mw, input logic [4:0] mn);
    @(posedge clk_sys);
    {flags_we, alu_flags, branch_exchange, bx_target_state, mode_we, mode_new} <=
      {fw, fl, bx, st, mw, mn};
    @(posedge clk_sys);
    {flags_we, branch_exchange, mode_we} <= 3'h0;
  endtask : pipe
endmodule : exception_source_model

// [test/test_cpu_mode_exception_control.sv]
// Self-checking bench for the status word and exception entry unit.
module test_cpu_mode_exception_control;
  import psw_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, resetn, avs_read, avs_write, avs_waitrequest, vector_valid;
  logic fiq_req, irq_req, high_vector_select, data_abort, prefetch_abort;
  logic illegal_opcode, software_trap, branch_exchange, bx_target_state, flags_we, mode_we;
  logic [3:0]  avs_address, avs_byteenable, alu_flags;
  logic [4:0]  mode_new;
  logic [31:0] avs_writedata, avs_readdata, return_addr, psw_out, stack_pointer;
  logic [31:0] vector_addr, saved_psw, saved_return, q;
  int err_total = 0;
  int n_checks = 0;
  logic [3:0]  cz [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
  logic [7:0]  vo [4] = '{VOFF_TRAP, VOFF_ILLEGAL, VOFF_PREFETCH, VOFF_DATA};
  cpu_mode_t   md [4] = '{MODE_SUPV, MODE_ILLG, MODE_ABRT, MODE_ABRT};

  cpu_mode_exception_control DUT (.clk_sys, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .fiq_req, .irq_req,
    .high_vector_select, .data_abort, .prefetch_abort, .illegal_opcode, .software_trap,
    .branch_exchange, .bx_target_state, .flags_we, .alu_flags, .mode_we, .mode_new,
    .return_addr, .psw_out, .stack_pointer, .vector_valid, .vector_addr, .saved_psw,
    .saved_return);
  exception_source_model src (.clk_sys, .fiq_req, .irq_req, .high_vector_select, .data_abort,
    .prefetch_abort, .illegal_opcode, .software_trap, .branch_exchange, .bx_target_state,
    .flags_we, .alu_flags, .mode_we, .mode_new, .return_addr);

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk

  // Request is held until waitrequest is sampled low, then released.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n == 20) begin
      err_total++;
      results();
    end
  endtask : bus

  task automatic expect_entry(input logic [31:0] va, input logic [31:0] ps, input logic [31:0] sp);
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (vector_valid === 1'b1) break;
    end
    if (n == 20) begin
      err_total++;
      results();
    end
    chk("vector_addr", va, vector_addr);
    chk("psw_out", ps, psw_out);
    chk("saved_psw", sp, saved_psw);
    chk("saved_return", 32'h00001234, saved_return);
  endtask : expect_entry

  task automatic expect_quiet();
    repeat (8) begin
      @(posedge clk_sys);
      chk("vector_valid", 32'h00000000, {31'h0, vector_valid});
    end
  endtask : expect_quiet

  initial begin
    resetn = 1'b0;
    {avs_read, avs_write} = 2'b00;
    avs_address = 4'h0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    expect_entry(VEC_BASE_LOW + 32'h0, PSW_RESET, PSW_RESET);
    bus(1'b0, ADDR_PSW, 32'h0);
    chk("psw reset", 32'h000000D3, q);
    bus(1'b1, ADDR_PSW, 32'h0FFFFFD3);
    bus(1'b0, ADDR_PSW, 32'h0);
    chk("psw reserved", 32'h000000D3, q);
    bus(1'b1, 4'h2, 32'hFFFFFFFF);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h00000000, q);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ADDR_PSW, 32'h00000030);
      src.pulse(cz[i]);
      expect_entry({24'h0, vo[i]}, {24'h0, 3'b100, md[i]}, 32'h00000030);
    end
    bus(1'b1, ADDR_PSW, 32'h00000030);
    src.set_int(1'b0, 1'b1);
    expect_entry({24'h0, VOFF_IRQ}, 32'h00000092, 32'h00000030);
    src.set_int(1'b0, 1'b0);
    bus(1'b1, ADDR_PSW, 32'h00000030);
    src.set_int(1'b1, 1'b1);
    expect_entry({24'h0, VOFF_FIQ}, 32'h000000D1, 32'h00000030);
    src.set_int(1'b0, 1'b0);
    bus(1'b1, ADDR_PSW, 32'h00000030);
    src.pulse(4'hE);
    expect_entry({24'h0, VOFF_DATA}, 32'h00000097, 32'h00000030);
    bus(1'b1, ADDR_PSW, 32'h00000030);
    src.pulse(4'h6);
    expect_entry({24'h0, VOFF_PREFETCH}, 32'h00000097, 32'h00000030);
    bus(1'b1, ADDR_PSW, 32'h0000009F);
    src.set_int(1'b0, 1'b1);
    expect_quiet();
    bus(1'b1, ADDR_PSW, 32'h0000001F);
    expect_entry({24'h0, VOFF_IRQ}, 32'h00000092, 32'h0000001F);
    src.set_int(1'b0, 1'b0);
    bus(1'b1, ADDR_PSW, 32'h0000005F);
    src.set_int(1'b1, 1'b0);
    expect_quiet();
    bus(1'b1, ADDR_PSW, 32'h0000001F);
    expect_entry({24'h0, VOFF_FIQ}, 32'h000000D1, 32'h0000001F);
    src.set_int(1'b0, 1'b0);
    bus(1'b1, ADDR_CTRL, 32'h00000001);
    bus(1'b1, ADDR_PSW, 32'h00000030);
    src.pulse(4'h1);
    expect_entry(VEC_BASE_HIGH + 32'h8, 32'h00000093, 32'h00000030);
    bus(1'b0, ADDR_VECTOR, 32'h0);
    chk("vector reg", VEC_BASE_HIGH + 32'h8, q);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl reg", 32'h00000001, q);
    bus(1'b1, ADDR_CTRL, 32'h00000000);
    bus(1'b1, ADDR_SP, 32'h00001000);
    bus(1'b0, ADDR_SP, 32'h0);
    chk("sp supv", 32'h00001000, q);
    bus(1'b1, ADDR_PSW, 32'h00000012);
    repeat (2) @(posedge clk_sys);
    chk("sp irq", 32'h00000000, stack_pointer);
    chk("spsr irq", 32'h0000001F, saved_psw);
    bus(1'b1, ADDR_SP, 32'h00002000);
    bus(1'b1, ADDR_PSW, 32'h00000013);
    repeat (2) @(posedge clk_sys);
    chk("sp back", 32'h00001000, stack_pointer);
    chk("spsr supv", 32'h00000030, saved_psw);
    bus(1'b1, ADDR_PSW, 32'h00000010);
    src.pipe(1'b1, 4'hA, 1'b0, 1'b0, 1'b0, 5'h10);
    repeat (2) @(posedge clk_sys);
    chk("flags", 32'hA0000010, psw_out);
    src.pipe(1'b0, 4'h0, 1'b1, 1'b1, 1'b0, 5'h10);
    repeat (2) @(posedge clk_sys);
    chk("state", 32'hA0000030, psw_out);
    src.pipe(1'b0, 4'h0, 1'b0, 1'b0, 1'b1, 5'h13);
    repeat (2) @(posedge clk_sys);
    chk("user mode_we", 32'hA0000030, psw_out);
    bus(1'b1, ADDR_PSW, 32'h0000001F);
    bus(1'b0, ADDR_PSW, 32'h0);
    chk("user write", 32'hA0000030, q);
    results();
  end
endmodule : test_cpu_mode_exception_control
